//--- sfsw_device.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
// Purpose: serial flash device end: status write, protection, reads
// Assumes: link clock far slower than CLOCK_I, sampled by two flops
// Notes: small array; program writes the last byte sent
module sfsw_device (
  input  wire logic                          CLOCK_I,
  input  wire logic                          RESETN_I,
  input  wire logic                          CE_I,
  sfsw_link_if.device                        LINK,
  output logic [sfsw_pkg::BYTE_W-1:0]        STATUS_O,
  output logic [sfsw_pkg::BYTE_W-1:0]        CONFIG_O,
  output logic [sfsw_pkg::BYTE_W-1:0]        POWER_PERF_O,
  output logic                               HW_PROTECT_O,
  output logic [3:0]                         DUAL_IO_DUMMY_O
);
  import sfsw_pkg::*;

  typedef enum logic [5:0] {
    D_CMD   = 6'b000001,
    D_ADDR  = 6'b000010,
    D_DUMMY = 6'b000100,
    D_DIN   = 6'b001000,
    D_DOUT  = 6'b010000,
    D_SKIP  = 6'b100000
  } sfsw_dst_t;

  typedef struct packed {
    sfsw_dst_t                  st;
    logic                       sclk_d;
    logic                       cs_d;
    logic [4:0]                 bits;
    logic [7:0]                 sh;
    logic [7:0]                 op;
    logic [23:0]                addr;
    logic [1:0]                 nb;
    logic                       over;
    logic [23:0]                wbuf;
    logic [2:0]                 ocnt;
    logic [7:0]                 osh;
    logic                       cfsel;
    logic                       o0;
    logic                       o1;
    logic                       oe0;
    logic                       oe1;
    logic                       lock;
    logic                       qe;
    logic [3:0]                 bp;
    logic                       write_latch_bit;
    logic                       busy;
    logic                       dc;
    logic                       lh;
    logic [10:0]                tmr;
    logic [MEM_BYTES-1:0][7:0]  mem;
  } sfsw_dev_t;

  sfsw_dev_t  dev_reg, dev_next;
  logic [3:0] pins_s;
  logic       s_cs, s_sclk, s_io0, s_wp;
  logic       rise, fall, cs_rise, hw_prot;
  logic [7:0] bin, srb, cf1b, cf2b, fresh, obyte, status_b;
  logic [MEM_AW-1:0] idx;

  function automatic logic prot_hit(input logic [MEM_AW-1:0] a, input logic [3:0] bp);
    return (bp != 4'h0) && ({1'b0, a} >= (MEM_SIZE7 - {1'b0, bp, 2'b00}));
  endfunction : prot_hit

  sfsw_sync #(
    .W    (4),
    .INIT (4'b1011)
  ) u_sync (
    .clk_i    (CLOCK_I),
    .resetn_i (RESETN_I),
    .ce_i     (CE_I),
    .d_i      ({LINK.cs_n, LINK.sclk, LINK.io0, LINK.wp_n}),
    .q_o      (pins_s)
  );

  assign {s_cs, s_sclk, s_io0, s_wp} = pins_s;
  assign idx = dev_reg.addr[MEM_AW-1:0];
  assign hw_prot = dev_reg.lock & ~s_wp;
  assign status_b = {dev_reg.lock, dev_reg.qe, dev_reg.bp, dev_reg.write_latch_bit, dev_reg.busy};

  always_comb begin
    dev_next = dev_reg;
    rise     = s_sclk & ~dev_reg.sclk_d;
    fall     = ~s_sclk & dev_reg.sclk_d;
    cs_rise  = s_cs & ~dev_reg.cs_d;
    bin      = {dev_reg.sh[6:0], s_io0};
    srb      = dev_reg.wbuf[7:0];
    cf1b     = {1'b0, dev_reg.dc, 6'h00};
    cf2b     = {6'h00, dev_reg.lh, 1'b0};
    fresh    = dev_reg.mem[idx];
    obyte    = dev_reg.osh;
    dev_next.sclk_d = s_sclk;
    dev_next.cs_d   = s_cs;

    // cycle end clears busy and latch
    if (dev_reg.busy) begin
      if (dev_reg.tmr == 11'h000) begin
        dev_next.busy = 1'b0;
        dev_next.write_latch_bit  = 1'b0;
      end else begin
        dev_next.tmr = dev_reg.tmr - 11'h001;
      end
    end

    if (dev_reg.nb == 2'd2) begin
      srb  = dev_reg.wbuf[15:8];
      cf1b = dev_reg.wbuf[7:0];
    end else if (dev_reg.nb == 2'd3) begin
      srb  = dev_reg.wbuf[23:16];
      cf1b = dev_reg.wbuf[15:8];
      cf2b = dev_reg.wbuf[7:0];
    end

    if (s_cs) begin
      dev_next.st   = D_CMD;
      dev_next.bits = 5'h00;
      dev_next.nb   = 2'd0;
      dev_next.over = 1'b0;
      dev_next.oe0  = 1'b0;
      dev_next.oe1  = 1'b0;
      if (cs_rise && dev_reg.st == D_DIN && dev_reg.bits == 5'h00) begin
        case (dev_reg.op)
          OP_LATCH_SET: begin
            // latch set in either protection state
            if (dev_reg.nb == 2'd0 && !dev_reg.over) begin
              dev_next.write_latch_bit = 1'b1;
            end
          end
          OP_STATUS_WRITE: begin
            if (dev_reg.nb != 2'd0 && !dev_reg.over && dev_reg.write_latch_bit && !hw_prot) begin
              // latch and busy bits not written
              dev_next.lock = srb[SR_LOCK];
              dev_next.qe   = srb[SR_QE];
              dev_next.bp   = srb[SR_BP+3:SR_BP];
              dev_next.dc   = cf1b[CF1_DC];
              dev_next.lh   = cf2b[CF2_LH];
              dev_next.busy = 1'b1;
              // mode switch uses its own time
              if (cf2b[CF2_LH] != dev_reg.lh) begin
                dev_next.tmr = MS_CYC - 11'h001;
              end else begin
                dev_next.tmr = SW_CYC - 11'h001;
              end
            end
          end
          OP_PROGRAM: begin
            if (dev_reg.nb != 2'd0 && dev_reg.write_latch_bit) begin
              if (prot_hit(idx, dev_reg.bp)) begin
                dev_next.write_latch_bit = 1'b0;
              end else begin
                dev_next.mem[idx] = dev_reg.mem[idx] & dev_reg.wbuf[7:0];
                dev_next.busy     = 1'b1;
                dev_next.tmr      = PROG_CYC - 11'h001;
              end
            end
          end
          OP_CHIP_ERASE: begin
            if (dev_reg.nb == 2'd0 && !dev_reg.over && dev_reg.write_latch_bit) begin
              if (dev_reg.bp != 4'h0) begin
                dev_next.write_latch_bit = 1'b0;
              end else begin
                for (int i = 0; i < MEM_BYTES; i++) begin
                  dev_next.mem[i] = MEM_RESET;
                end
                dev_next.busy = 1'b1;
                dev_next.tmr  = ERASE_CYC - 11'h001;
              end
            end
          end
          default: ;
        endcase
      end
    end else if (rise) begin
      case (dev_reg.st)
        D_CMD: begin
          dev_next.sh   = bin;
          dev_next.bits = dev_reg.bits + 5'h01;
          if (dev_reg.bits == 5'h07) begin
            dev_next.bits  = 5'h00;
            dev_next.op    = bin;
            dev_next.ocnt  = 3'h0;
            dev_next.cfsel = 1'b0;
            if (dev_reg.busy && bin != OP_READ_STATUS && bin != OP_READ_CONFIG) begin
              dev_next.st = D_SKIP;
            end else if (bin == OP_READ || bin == OP_FAST_READ || bin == OP_DUAL_OUT
                         || bin == OP_PROGRAM) begin
              dev_next.st = D_ADDR;
            end else if (bin == OP_READ_STATUS || bin == OP_READ_CONFIG) begin
              dev_next.st = D_DOUT;
            end else if (bin == OP_LATCH_SET || bin == OP_STATUS_WRITE
                         || bin == OP_CHIP_ERASE) begin
              dev_next.st = D_DIN;
            end else begin
              dev_next.st = D_SKIP;
            end
          end
        end
        D_ADDR: begin
          // three address bytes on rising edges
          dev_next.addr = {dev_reg.addr[22:0], s_io0};
          dev_next.bits = dev_reg.bits + 5'h01;
          if (dev_reg.bits == 5'h17) begin
            dev_next.bits = 5'h00;
            if (dev_reg.op == OP_PROGRAM) begin
              dev_next.st = D_DIN;
            end else if (dev_reg.op == OP_READ) begin
              dev_next.st = D_DOUT;
            end else begin
              dev_next.st = D_DUMMY;
            end
          end
        end
        D_DUMMY: begin
          dev_next.bits = dev_reg.bits + 5'h01;
          if (dev_reg.bits == RD_DUMMY_CLKS - 5'h01) begin
            dev_next.bits = 5'h00;
            dev_next.st   = D_DOUT;
          end
        end
        D_DIN: begin
          dev_next.sh   = bin;
          dev_next.bits = (dev_reg.bits == 5'h07) ? 5'h00 : dev_reg.bits + 5'h01;
          if (dev_reg.bits == 5'h07) begin
            dev_next.wbuf = {dev_reg.wbuf[15:0], bin};
            if (dev_reg.nb == 2'd3) begin
              dev_next.over = 1'b1;
            end else begin
              dev_next.nb = dev_reg.nb + 2'd1;
            end
          end
        end
        default: ;
      endcase
    end else if (fall && dev_reg.st == D_DOUT) begin
      // status reads stay live so busy can be polled
      if (dev_reg.op == OP_READ_STATUS) begin
        fresh = status_b;
      end else if (dev_reg.op == OP_READ_CONFIG) begin
        fresh = dev_reg.cfsel ? cf2b : cf1b;
      end
      if (dev_reg.ocnt == 3'h0) begin
        obyte = fresh;
      end
      dev_next.o1  = obyte[7];
      dev_next.oe1 = 1'b1;
      if (dev_reg.op == OP_DUAL_OUT) begin
        dev_next.o0   = obyte[6];
        dev_next.oe0  = 1'b1;
        dev_next.osh  = {obyte[5:0], 2'b00};
        dev_next.ocnt = dev_reg.ocnt + 3'h2;
      end else begin
        dev_next.osh  = {obyte[6:0], 1'b0};
        dev_next.ocnt = dev_reg.ocnt + 3'h1;
      end
      if (dev_next.ocnt == 3'h0) begin
        dev_next.cfsel = ~dev_reg.cfsel;
        if (idx == MEM_AW'(MEM_BYTES - 1)) begin
          dev_next.addr = 24'h000000;
        end else begin
          dev_next.addr = dev_reg.addr + 24'h000001;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      dev_reg        <= '0;
      dev_reg.st     <= D_CMD;
      dev_reg.sclk_d <= 1'b0;
      dev_reg.cs_d   <= 1'b1;
      {dev_reg.lock, dev_reg.qe, dev_reg.bp, dev_reg.write_latch_bit, dev_reg.busy} <= SR_RESET;
      dev_reg.dc     <= CF_RESET[CF1_DC];
      dev_reg.lh     <= CF_RESET[CF2_LH];
      dev_reg.mem    <= {MEM_BYTES{MEM_RESET}};
    end else if (CE_I) begin
      dev_reg <= dev_next;
    end
  end

  assign LINK.dev_io0    = dev_reg.o0;
  assign LINK.dev_io0_oe = dev_reg.oe0;
  assign LINK.dev_io1    = dev_reg.o1;
  assign LINK.dev_io1_oe = dev_reg.oe1;
  assign STATUS_O        = status_b;
  assign CONFIG_O        = {1'b0, dev_reg.dc, 6'h00};
  assign POWER_PERF_O    = {6'h00, dev_reg.lh, 1'b0};
  assign HW_PROTECT_O    = hw_prot;
  assign DUAL_IO_DUMMY_O = io_dummy_clocks(dev_reg.dc, 1'b0);
endmodule : sfsw_device

//--- sfsw_pkg.sv
// Purpose: shared constants for the serial flash link, device and host ends
// Assumes: 25 MHz system clock on both ends
// Notes: opcodes and sizes are plain defaults
package sfsw_pkg;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PROGRAM      = 8'h02;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;
  localparam logic [7:0] OP_READ_CONFIG  = 8'h15;
  localparam logic [7:0] OP_DUAL_OUT     = 8'h3b;
  localparam logic [7:0] OP_CHIP_ERASE   = 8'h60;
  localparam int BYTE_W = 8;
  localparam int SR_LOCK = 7;
  localparam int SR_QE   = 6;
  localparam int SR_BP   = 2;
  localparam int CF1_DC  = 6;
  localparam int CF2_LH  = 1;
  localparam logic [7:0] SR_RESET  = 8'h00;
  localparam logic [7:0] CF_RESET  = 8'h00;
  localparam logic [7:0] MEM_RESET = 8'hff;
  localparam int MEM_AW = 6;
  localparam int MEM_BYTES = 64;
  localparam logic [6:0] MEM_SIZE7 = 7'h40;
  localparam logic [4:0] RD_DUMMY_CLKS = 5'h08;
  localparam logic [3:0] DC_DUAL_CLR = 4'h4;
  localparam logic [3:0] DC_DUAL_SET = 4'h8;
  localparam logic [3:0] DC_QUAD_CLR = 4'h6;
  localparam logic [3:0] DC_QUAD_SET = 4'ha;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STATUS_WRITE_TIME_NS = 8000;
  localparam int MODE_SWITCH_WRITE_TIME_NS = 30000;
  localparam int PROGRAM_TIME_NS = 2000;
  localparam int ERASE_TIME_NS = 20000;
  localparam logic [10:0] SW_CYC =
    11'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] MS_CYC =
    11'((MODE_SWITCH_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] PROG_CYC =
    11'((PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] ERASE_CYC =
    11'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] SCLK_HALF = 3'h4;
  localparam logic [3:0] HR_CMD  = 4'h0;
  localparam logic [3:0] HR_ADDR = 4'h1;
  localparam logic [3:0] HR_TX   = 4'h2;
  localparam logic [3:0] HR_LEN  = 4'h3;
  localparam logic [3:0] HR_PINS = 4'h4;
  localparam logic [3:0] HR_STAT = 4'h5;
  localparam logic [3:0] HR_RX   = 4'h6;
  localparam int CMD_ADDR_EN  = 8;
  localparam int CMD_DUMMY_EN = 9;
  localparam int CMD_DUAL     = 10;
  localparam logic PINS_WP_RESET = 1'b1;

  function automatic logic [3:0] io_dummy_clocks(input logic dc, input logic quad);
    if (quad) begin
      return dc ? DC_QUAD_SET : DC_QUAD_CLR;
    end
    return dc ? DC_DUAL_SET : DC_DUAL_CLR;
  endfunction : io_dummy_clocks
endpackage : sfsw_pkg

//--- sfsw_link_if.sv
`timescale 1ns/1ps
// Purpose: serial flash link between host and device ends
// Assumes: lines idle high through pull-ups
// Notes: resolves shared io lines from the enables
interface sfsw_link_if;
  logic cs_n;
  logic sclk;
  logic wp_n;
  logic host_io0;
  logic host_io0_oe;
  logic dev_io0;
  logic dev_io0_oe;
  logic dev_io1;
  logic dev_io1_oe;
  logic io0;
  logic io1;

  assign io0 = dev_io0_oe ? dev_io0 : (host_io0_oe ? host_io0 : 1'b1);
  assign io1 = dev_io1_oe ? dev_io1 : 1'b1;

  modport host (output cs_n, output sclk, output wp_n, output host_io0,
                output host_io0_oe, input io0, input io1);
  modport device (input cs_n, input sclk, input wp_n, input io0,
                  output dev_io0, output dev_io0_oe, output dev_io1, output dev_io1_oe);
endinterface : sfsw_link_if

//--- sfsw_sync.sv
`timescale 1ns/1ps
// Purpose: two-stage synchroniser for pins entering the clock domain
// Assumes: inputs are levels
// Notes: only the second stage leaves the module
module sfsw_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfsw_sync_t;
  sfsw_sync_t sync_reg, sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d_i;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync_reg <= {INIT, INIT};
    end else if (ce_i) begin
      sync_reg <= sync_next;
    end
  end

  assign q_o = sync_reg.s2;
endmodule : sfsw_sync

//--- sfsw_host.sv
`timescale 1ns/1ps
// Purpose: host controller end driving select, clock and data pins
// Assumes: software polls busy before each new command
// Notes: read data sampled at end of each high phase
module sfsw_host (
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CE_I,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  output logic             BUSY_O,
  sfsw_link_if.host        LINK
);
  import sfsw_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_LEAD  = 5'b00010,
    H_HIGH  = 5'b00100,
    H_LOW   = 5'b01000,
    H_TRAIL = 5'b10000
  } sfsw_hst_t;

  typedef struct packed {
    sfsw_hst_t   st;
    logic [2:0]  div;
    logic        sclk;
    logic        cs_n;
    logic        io0;
    logic        io0_oe;
    logic        wp;
    logic [10:0] cmd;
    logic [55:0] txsh;
    logic [11:0] k;
    logic [11:0] drv_end;
    logic [11:0] rx_beg;
    logic [11:0] total;
    logic [23:0] addr;
    logic [23:0] txd;
    logic [1:0]  txlen;
    logic [7:0]  rxlen;
    logic [31:0] rx;
    logic [31:0] rdata;
  } sfsw_host_t;

  sfsw_host_t  h_reg, h_next;
  logic [1:0]  io_s;
  logic        tick;
  logic [11:0] ntx, ndum;

  sfsw_sync #(
    .W    (2),
    .INIT (2'b11)
  ) u_sync (
    .clk_i    (CLOCK_I),
    .resetn_i (RESETN_I),
    .ce_i     (CE_I),
    .d_i      ({LINK.io1, LINK.io0}),
    .q_o      (io_s)
  );

  assign tick = (h_reg.div == SCLK_HALF - 3'h1);

  always_comb begin
    h_next = h_reg;
    ntx    = 12'h008 + (WDATA_I[CMD_ADDR_EN] ? 12'h018 : 12'h000)
             + {7'h00, h_reg.txlen, 3'h0};
    ndum   = WDATA_I[CMD_DUMMY_EN] ? 12'(RD_DUMMY_CLKS) : 12'h000;
    h_next.div = tick ? 3'h0 : h_reg.div + 3'h1;
    if (RD_I) begin
      if (ADDR_I == HR_CMD) begin
        h_next.rdata = {21'h0, h_reg.cmd};
      end else if (ADDR_I == HR_ADDR) begin
        h_next.rdata = {8'h00, h_reg.addr};
      end else if (ADDR_I == HR_TX) begin
        h_next.rdata = {8'h00, h_reg.txd};
      end else if (ADDR_I == HR_LEN) begin
        h_next.rdata = {16'h0, h_reg.rxlen, 6'h00, h_reg.txlen};
      end else if (ADDR_I == HR_PINS) begin
        h_next.rdata = {31'h0, h_reg.wp};
      end else if (ADDR_I == HR_STAT) begin
        h_next.rdata = {31'h0, h_reg.st != H_IDLE};
      end else if (ADDR_I == HR_RX) begin
        h_next.rdata = h_reg.rx;
      end else begin
        h_next.rdata = 32'h0;
      end
    end
    // setup registers are frozen while a frame runs
    if (WR_I && h_reg.st == H_IDLE) begin
      if (ADDR_I == HR_ADDR) begin
        h_next.addr = WDATA_I[23:0];
      end else if (ADDR_I == HR_TX) begin
        h_next.txd = WDATA_I[23:0];
      end else if (ADDR_I == HR_LEN) begin
        h_next.txlen = WDATA_I[1:0];
        h_next.rxlen = WDATA_I[15:8];
      end else if (ADDR_I == HR_PINS) begin
        h_next.wp = WDATA_I[0];
      end else if (ADDR_I == HR_CMD) begin
        // latch set is its own earlier command
        h_next.cmd    = WDATA_I[10:0];
        h_next.txsh   = WDATA_I[CMD_ADDR_EN] ? {WDATA_I[7:0], h_reg.addr, h_reg.txd}
                                             : {WDATA_I[7:0], h_reg.txd, 24'h0};
        h_next.rx_beg = ntx + ndum;
        h_next.drv_end = WDATA_I[CMD_DUAL] ? ntx : ntx + ndum;
        h_next.total  = ntx + ndum + (WDATA_I[CMD_DUAL] ? {2'b00, h_reg.rxlen, 2'b00}
                                                         : {1'b0, h_reg.rxlen, 3'h0});
        h_next.k      = 12'h000;
        h_next.div    = 3'h0;
        // select low, first bit on the line
        h_next.cs_n   = 1'b0;
        h_next.io0    = WDATA_I[7];
        h_next.io0_oe = 1'b1;
        h_next.st     = H_LEAD;
      end
    end
    case (h_reg.st)
      H_LEAD, H_LOW: begin
        if (tick) begin
          h_next.sclk = 1'b1;
          h_next.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          // sample before the device shifts on the fall
          if (h_reg.k >= h_reg.rx_beg) begin
            h_next.rx = h_reg.cmd[CMD_DUAL] ? {h_reg.rx[29:0], io_s}
                                           : {h_reg.rx[30:0], io_s[1]};
          end
          h_next.sclk   = 1'b0;
          h_next.k      = h_reg.k + 12'h001;
          h_next.txsh   = {h_reg.txsh[54:0], 1'b0};
          h_next.io0    = h_reg.txsh[54];
          h_next.io0_oe = (h_reg.k + 12'h001) < h_reg.drv_end;
          h_next.st     = ((h_reg.k + 12'h001) == h_reg.total) ? H_TRAIL : H_LOW;
        end
      end
      H_TRAIL: begin
        if (tick) begin
          h_next.cs_n   = 1'b1;
          h_next.io0_oe = 1'b0;
          h_next.st     = H_IDLE;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      h_reg      <= '0;
      h_reg.st   <= H_IDLE;
      h_reg.cs_n <= 1'b1;
      h_reg.wp   <= PINS_WP_RESET;
    end else if (CE_I) begin
      h_reg <= h_next;
    end
  end

  assign LINK.cs_n        = h_reg.cs_n;
  assign LINK.sclk        = h_reg.sclk;
  assign LINK.wp_n        = h_reg.wp;
  assign LINK.host_io0    = h_reg.io0;
  assign LINK.host_io0_oe = h_reg.io0_oe;
  assign RDATA_O          = h_reg.rdata;
  assign BUSY_O           = h_reg.st != H_IDLE;
endmodule : sfsw_host

//--- sfsw_link_monitor.sv
`timescale 1ns/1ps
// Purpose: link checker between host and device ends
// Assumes: one clock domain, sync low reset
// Notes: sclk half period is four cycles
module sfsw_link_monitor (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_io0,
  input wire logic host_io0_oe,
  input wire logic dev_io1,
  input wire logic dev_io0_oe,
  input wire logic dev_io1_oe
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  sequence high_phase; sclk [*4] ##1 !sclk; endsequence
  sequence low_phase; !sclk [*4]; endsequence
  clk_high_a: assert property ($rose(sclk) |-> high_phase)
    else $error("sclk high phase length");
  clk_low_a: assert property ($fell(sclk) |-> low_phase)
    else $error("sclk low phase length");
  clk_idle_a: assert property (cs_n |-> !sclk)
    else $error("sclk moves outside frame");
  sel_fall_a: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("select falls too near sclk");
  sel_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select idle gap short");
  drive_end_a: assert property ($rose(cs_n) |-> ##[1:5] !dev_io1_oe && !dev_io0_oe)
    else $error("device still drives");
  dev_shift_a: assert property (dev_io1_oe && $changed(dev_io1) |-> !sclk)
    else $error("device data moves while sclk high");
  host_shift_a: assert property (host_io0_oe && $changed(host_io0) |-> !sclk)
    else $error("host data moves while sclk high");
endmodule : sfsw_link_monitor

//--- serial_flash_status_write_read_bench.sv
`timescale 1ns/1ps
// Purpose: host and device ends joined over the link
// Assumes: 25 MHz clock, 5 cycle reset
// Notes: reads are queued and checked by a watcher
module serial_flash_status_write_read_bench;
  import sfsw_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, rd_p = 0, busy, hwp;
  logic [3:0] adr = 0, dum;
  logic [31:0] wd = 0, rdat;
  logic [7:0] st, cf, pp, d0, d1;
  logic [15:0] exq[$];
  int n_fail = 0, check_count = 0;
  localparam logic [10:0] FA = 11'h1 << CMD_ADDR_EN, FD = 11'h1 << CMD_DUMMY_EN;
  localparam logic [10:0] RC[3] = '{FA | OP_READ, FA | FD | OP_FAST_READ,
                                    FA | FD | (11'h1 << CMD_DUAL) | OP_DUAL_OUT};
  sfsw_link_if link();
  sfsw_host sfsw_host_inst(.CLOCK_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .ADDR_I(adr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .BUSY_O(busy), .LINK(link));
  sfsw_device sfsw_device_inst(.CLOCK_I(clk), .RESETN_I(rst_n), .CE_I(1'b1), .LINK(link),
    .STATUS_O(st), .CONFIG_O(cf), .POWER_PERF_O(pp), .HW_PROTECT_O(hwp), .DUAL_IO_DUMMY_O(dum));
  sfsw_link_monitor sfsw_link_monitor_inst(.CLOCK_I(clk), .RESETN_I(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io0(link.host_io0), .host_io0_oe(link.host_io0_oe),
    .dev_io1(link.dev_io1), .dev_io0_oe(link.dev_io0_oe), .dev_io1_oe(link.dev_io1_oe));
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic wreg(logic [3:0] a, logic [31:0] v);
    @(posedge clk); adr <= a; wd <= v; wr <= 1;
    @(posedge clk); wr <= 0;
  endtask : wreg
  task automatic rreg(logic [15:0] e);
    @(posedge clk); adr <= HR_RX; rd <= 1; exq.push_back(e);
    @(posedge clk); rd <= 0;
  endtask : rreg
  task automatic frame(logic [10:0] c, logic [23:0] a, logic [23:0] d, logic [15:0] n);
    wreg(HR_ADDR, {8'h0, a}); wreg(HR_TX, {8'h0, d});
    wreg(HR_LEN, {16'h0, n}); wreg(HR_CMD, {21'h0, c});
    @(posedge clk);
    check("busy", busy, 1'b1);
    for (int i = 0; i < 3000 && (busy !== 1'b0 || i < 3); i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : frame
  task automatic idle;
    for (int i = 0; i < 2000 && st[0] !== 1'b0; i++) @(posedge clk);
  endtask : idle
  always @(posedge clk) begin
    rd_p <= rd;
    if (rd_p) check("rx", {16'h0, rdat[15:0]}, {16'h0, exq.pop_front()});
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    d0 = lfsr(8'h01);
    d1 = lfsr(d0);
    repeat (5) @(posedge clk); rst_n <= 1;
    repeat (3) @(posedge clk);
    check("status", st, SR_RESET);
    check("dummy", dum, DC_DUAL_CLR);
    check("idle", busy, 1'b0);
    frame(OP_STATUS_WRITE, 0, 24'h9c0000, 1);
    check("no latch", st, SR_RESET);
    frame(OP_LATCH_SET, 0, 0, 0);
    frame(OP_STATUS_WRITE, 0, 0, 0);
    check("zero bits", st, 8'h02);
    for (int k = 0; k < 2; k++) begin
      frame(OP_LATCH_SET, 0, 0, 0);
      frame(FA | OP_PROGRAM, k ? 24'h0 : 24'(MEM_BYTES - 1), {k ? d1 : d0, 16'h0}, 1);
      idle();
    end
    foreach (RC[j]) begin
      frame(RC[j], 24'(MEM_BYTES - 1), 0, 16'h0200);
      rreg({d0, d1});
    end
    frame(OP_LATCH_SET, 0, 0, 0);
    frame(OP_STATUS_WRITE, 0, 24'h9c4002, 3);
    check("busy status", st, 8'h9f);
    frame(FA | FD | OP_FAST_READ, 0, 0, 16'h0200);
    rreg(16'hffff);
    check("mode time", st[0], 1'b1);
    frame(OP_READ_STATUS, 0, 0, 16'h0200);
    rreg(16'h9f9f);
    idle();
    check("done", st, 8'h9c);
    check("dummy set", dum, DC_DUAL_SET);
    check("perf", pp[CF2_LH], 1'b1);
    check("config", cf, 8'h1 << CF1_DC);
    frame(OP_READ_CONFIG, 0, 0, 16'h0200);
    rreg(16'h4002);
    wreg(HR_PINS, 0);
    repeat (4) @(posedge clk);
    check("hw on", hwp, 1'b1);
    frame(OP_LATCH_SET, 0, 0, 0);
    frame(OP_STATUS_WRITE, 0, 0, 1);
    check("locked", st, 8'h9e);
    frame(FA | OP_PROGRAM, 24'(MEM_BYTES - 1), 0, 1);
    idle();
    check("prot prog", st, 8'h9c);
    wreg(HR_PINS, 1);
    repeat (4) @(posedge clk);
    check("hw off", hwp, 1'b0);
    frame(OP_LATCH_SET, 0, 0, 0);
    frame(OP_CHIP_ERASE, 0, 0, 0);
    check("prot erase", st, 8'h9c);
    frame(FA | OP_READ, 24'(MEM_BYTES - 1), 0, 16'h0200);
    rreg({d0, d1});
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : serial_flash_status_write_read_bench
